/* hw/stoc_regs.vh */
// Purpose: Constants for the scan telegram output controller.
// Assumes: 100 MHz clock, Avalon-MM register port.
// Notes: Offsets are byte addresses of 32-bit words.
`ifndef STOC_REGS_VH
`define STOC_REGS_VH
`define STOC_ADDR_W 6
`define STOC_OFS_CTRL 6'h00
`define STOC_OFS_CMD 6'h04
`define STOC_OFS_STATUS 6'h08
`define STOC_OFS_ANSWER 6'h0c
`define STOC_OFS_SCANCNT 6'h10
`define STOC_OFS_CONFIG 6'h14
`define STOC_OFS_SCALE 6'h18
`define STOC_OFS_IFACE 6'h1c
`define STOC_CTRL_RESET 32'h00000000
`define STOC_STATE_MEASURE 4'h7
`define STOC_STATE_IDLE 4'h1
`define STOC_STATE_STARTING 4'h3
`define STOC_CMD_LOGIN 3'h1
`define STOC_CMD_START 3'h2
`define STOC_CMD_RUN 3'h3
`define STOC_CMD_QUERY 3'h4
`define STOC_CMD_SCAN_READ 3'h5
`define STOC_CMD_SCAN_SUB 3'h6
`define STOC_TYPE_METHOD_ANS 3'h1
`define STOC_TYPE_READ_ANS 3'h3
`define STOC_TYPE_EVENT_ACK 3'h5
`define STOC_TYPE_EVENT 3'h6
`define STOC_SETTLE_NS 1000
`define STOC_SETTLE_CYC (`STOC_SETTLE_NS / 10)
`define STOC_RANGE_FINE 8'h41
`define STOC_RANGE_COARSE 8'h50
`define STOC_FOG_RANGE 8'h07
`define STOC_OPEN_REDUCED 8'h5a
`define STOC_OPEN_FULL 8'hbe
`endif

/* hw/stoc_core.v */
// Purpose: Telegram command interpreter and scan output control.
// Assumes: Telegram framing is parsed upstream into command codes.
// Notes: Software drives commands through the register port.
//
// Our own choices: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "stoc_regs.vh"
module stoc_core #(
  parameter FULL_VARIANT = 1,
  parameter OUTDOOR = 1
) (
  input wire clk_in,
  input wire rst_n_in,
  input wire [`STOC_ADDR_W-1:0] avs_address_in,
  input wire avs_read_in,
  input wire avs_write_in,
  input wire [31:0] avs_writedata_in,
  input wire [3:0] avs_byteenable_in,
  output reg [31:0] avs_readdata_out,
  output wire avs_waitrequest_out,
  output reg [1:0] avs_response_out,
  input wire scan_done_in,
  input wire contam_warn_in,
  input wire contam_err_in,
  input wire field_hit_in,
  output reg led_warn_out,
  output reg led_err_out,
  output reg dout_out,
  output reg field_alarm_out,
  output reg tel_valid_out,
  output reg [2:0] tel_type_out,
  output reg [2:0] tel_cmd_out,
  output reg [7:0] tel_result_out,
  output reg [15:0] tel_scan_cnt_out,
  output reg tel_iface_out,
  output reg fog_enable_out,
  output reg [1:0] echo_mode_out,
  output reg [7:0] open_angle_out
);
  // ****************************************
  // Pin synchronisers
  // ****************************************
  reg [1:0] sync_done, sync_warn, sync_err, sync_hit;
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync_done <= 2'h0;
      sync_warn <= 2'h0;
      sync_err <= 2'h0;
      sync_hit <= 2'h0;
    end else begin
      sync_done <= {sync_done[0], scan_done_in};
      sync_warn <= {sync_warn[0], contam_warn_in};
      sync_err <= {sync_err[0], contam_err_in};
      sync_hit <= {sync_hit[0], field_hit_in};
    end
  end
  reg done_q;
  wire scan_tick = sync_done[1] & ~done_q;

  // ****************************************
  // Pairing lookup
  // ****************************************
  // Returns {valid, coarse, reduced_angle} for a frequency and resolution code.
  // Freq codes: 0=25,1=35,2=50,3=75,4=100 Hz.
  // Res codes: 0=0.1667,1=0.25,2=0.3333,3=0.5,4=0.6667,5=1 degree.
  function [2:0] pair_lookup;
    input [2:0] f;
    input [2:0] r;
    input full;
    begin
      pair_lookup = 3'h0;
      if (full) begin
        case ({f, r})
          6'h00: pair_lookup = 3'h4;
          6'h01: pair_lookup = 3'h6;
          6'h09: pair_lookup = 3'h4;
          6'h0b: pair_lookup = 3'h6;
          6'h12: pair_lookup = 3'h4;
          6'h13: pair_lookup = 3'h6;
          6'h1b: pair_lookup = 3'h4;
          6'h1d: pair_lookup = 3'h6;
          6'h24: pair_lookup = 3'h4;
          6'h25: pair_lookup = 3'h6;
          default: pair_lookup = 3'h0;
        endcase
      end else begin
        case ({f, r})
          6'h01, 6'h0b, 6'h13, 6'h1d: pair_lookup = 3'h6;
          6'h1b: pair_lookup = 3'h5;
          default: pair_lookup = 3'h0;
        endcase
      end
    end
  endfunction

  // ****************************************
  // Register bus
  // ****************************************
  localparam [1:0] RESP_OK = 2'h0;
  localparam [1:0] RESP_SLVERR = 2'h2;
  reg [3:0] dev_state;
  reg logged_in, subscribed, cfg_ok, coarse, req_iface;
  reg [5:0] cfg_pair;
  reg [1:0] echo_cfg;
  reg particle_en, fog_cfg, cfg_err;
  reg [15:0] scan_cnt, last_scan;
  reg have_scan, single_pend, sub_ack_pend;
  reg [2:0] ans_type, ans_cmd;
  reg [7:0] ans_result;
  reg [7:0] settle;
  wire [31:0] settle_init = `STOC_SETTLE_CYC;
  reg acc_done;
  wire acc = (avs_read_in | avs_write_in) & ~acc_done;
  assign avs_waitrequest_out = acc;
  // A write takes effect only in the cycle in which waitrequest is low.
  wire wr = avs_write_in & acc_done;

  // ****************************************
  // Command decode
  // ****************************************
  wire cmd_wr = wr && avs_address_in == `STOC_OFS_CMD;
  wire [2:0] cmd = avs_writedata_in[2:0];
  wire cmd_arg = avs_writedata_in[8];
  wire cmd_if = avs_writedata_in[9];
  wire [2:0] lk = pair_lookup(avs_writedata_in[2:0], avs_writedata_in[6:4],
    FULL_VARIANT != 0);
  wire measuring = dev_state == `STOC_STATE_MEASURE;

  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      acc_done <= 1'b0;
      avs_readdata_out <= 32'h0;
      avs_response_out <= RESP_OK;
    end else begin
      acc_done <= acc;
      if (avs_read_in & acc) begin
        avs_response_out <= RESP_OK;
        case (avs_address_in)
          `STOC_OFS_CTRL: avs_readdata_out <= {25'h0, fog_cfg, particle_en, echo_cfg,
            cfg_err, 2'h0};
          `STOC_OFS_STATUS: avs_readdata_out <= {22'h0, sync_err[1], sync_warn[1],
            subscribed, logged_in, 2'h0, dev_state};
          `STOC_OFS_ANSWER: avs_readdata_out <= {15'h0, ans_type, 3'h0, ans_cmd,
            ans_result};
          `STOC_OFS_SCANCNT: avs_readdata_out <= {16'h0, scan_cnt};
          `STOC_OFS_CONFIG: avs_readdata_out <= {25'h0, cfg_pair[2:0], 1'b0,
            cfg_pair[5:3]};
          `STOC_OFS_SCALE: avs_readdata_out <= {15'h0, cfg_ok, 8'h0,
            coarse ? `STOC_RANGE_COARSE : `STOC_RANGE_FINE};
          `STOC_OFS_IFACE: avs_readdata_out <= {31'h0, req_iface};
          default: begin
            avs_readdata_out <= 32'h0;
            avs_response_out <= RESP_SLVERR;
          end
        endcase
      end else if (wr) begin
        avs_response_out <= RESP_OK;
      end
    end
  end

  // ****************************************
  // Configuration
  // ****************************************
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cfg_pair <= 6'h0b;
      cfg_ok <= 1'b1;
      coarse <= 1'b1;
      cfg_err <= 1'b0;
      echo_cfg <= 2'h0;
      particle_en <= 1'b0;
      fog_cfg <= 1'b0;
    end else if (wr && avs_address_in == `STOC_OFS_CONFIG && avs_byteenable_in[0]) begin
      if (lk[2]) begin
        cfg_pair <= {avs_writedata_in[2:0], avs_writedata_in[6:4]};
        coarse <= lk[1];
        cfg_ok <= 1'b1;
        cfg_err <= 1'b0;
      end else begin
        cfg_err <= 1'b1;
      end
    end else if (wr && avs_address_in == `STOC_OFS_CTRL && avs_byteenable_in[0]) begin
      echo_cfg <= avs_writedata_in[4:3];
      particle_en <= avs_writedata_in[5];
      fog_cfg <= avs_writedata_in[6];
    end
  end

  // ****************************************
  // Filters and indicators
  // ****************************************
  reg hit_d;
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      fog_enable_out <= 1'b0;
      echo_mode_out <= 2'h0;
      open_angle_out <= `STOC_OPEN_FULL;
      led_warn_out <= 1'b0;
      led_err_out <= 1'b0;
      dout_out <= 1'b0;
      field_alarm_out <= 1'b0;
      hit_d <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= sync_done[1];
      fog_enable_out <= (OUTDOOR != 0) | fog_cfg;
      echo_mode_out <= (echo_cfg == 2'h3) ? 2'h0 : echo_cfg;
      open_angle_out <= (FULL_VARIANT == 0 && cfg_pair == 6'h1b) ?
        `STOC_OPEN_REDUCED : `STOC_OPEN_FULL;
      led_warn_out <= sync_warn[1];
      led_err_out <= sync_err[1];
      dout_out <= sync_err[1] | ~measuring;
      if (scan_tick)
        hit_d <= sync_hit[1];
      field_alarm_out <= particle_en ? hit_d : sync_hit[1];
    end
  end

  // ****************************************
  // Command sequencer
  // ****************************************
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dev_state <= `STOC_STATE_IDLE;
      logged_in <= 1'b0;
      subscribed <= 1'b0;
      req_iface <= 1'b0;
      settle <= 8'h0;
      scan_cnt <= 16'h0;
      last_scan <= 16'h0;
      have_scan <= 1'b0;
      single_pend <= 1'b0;
      sub_ack_pend <= 1'b0;
      ans_type <= 3'h0;
      ans_cmd <= 3'h0;
      ans_result <= 8'h0;
      tel_valid_out <= 1'b0;
      tel_type_out <= 3'h0;
      tel_cmd_out <= 3'h0;
      tel_result_out <= 8'h0;
      tel_scan_cnt_out <= 16'h0;
      tel_iface_out <= 1'b0;
    end else begin
      tel_valid_out <= 1'b0;
      if (dev_state == `STOC_STATE_STARTING) begin
        if (settle == 8'h0)
          dev_state <= `STOC_STATE_MEASURE;
        else
          settle <= settle - 8'h01;
      end
      if (sync_err[1] && measuring)
        dev_state <= `STOC_STATE_IDLE;
      if (scan_tick && measuring) begin
        scan_cnt <= scan_cnt + 16'h0001;
        last_scan <= scan_cnt;
        have_scan <= 1'b1;
      end
      if (cmd_wr) begin
        ans_cmd <= cmd;
        ans_type <= `STOC_TYPE_METHOD_ANS;
        ans_result <= 8'h0;
        case (cmd)
          `STOC_CMD_LOGIN: logged_in <= 1'b1;
          `STOC_CMD_START: ans_result <= logged_in ? 8'h00 : 8'h01;
          `STOC_CMD_RUN: begin
            logged_in <= 1'b0;
            if (dev_state == `STOC_STATE_IDLE && !sync_err[1]) begin
              dev_state <= `STOC_STATE_STARTING;
              settle <= settle_init[7:0];
            end
          end
          `STOC_CMD_QUERY: begin
            ans_type <= `STOC_TYPE_READ_ANS;
            ans_result <= {4'h0, dev_state};
          end
          `STOC_CMD_SCAN_READ: begin
            ans_type <= `STOC_TYPE_READ_ANS;
            req_iface <= cmd_if;
            single_pend <= measuring & have_scan;
          end
          `STOC_CMD_SCAN_SUB: begin
            ans_type <= `STOC_TYPE_EVENT_ACK;
            ans_result <= {7'h0, cmd_arg};
            req_iface <= cmd_if;
            subscribed <= cmd_arg & measuring;
            sub_ack_pend <= 1'b1;
          end
          default: ans_result <= 8'hff;
        endcase
      end else if (sub_ack_pend) begin
        sub_ack_pend <= 1'b0;
        tel_valid_out <= 1'b1;
        tel_type_out <= `STOC_TYPE_EVENT_ACK;
        tel_cmd_out <= `STOC_CMD_SCAN_SUB;
        tel_result_out <= ans_result;
        tel_iface_out <= req_iface;
      end else if (single_pend) begin
        single_pend <= 1'b0;
        tel_valid_out <= 1'b1;
        tel_type_out <= `STOC_TYPE_READ_ANS;
        tel_cmd_out <= `STOC_CMD_SCAN_READ;
        tel_result_out <= {7'h0, coarse};
        tel_scan_cnt_out <= last_scan;
        tel_iface_out <= req_iface;
      end else if (subscribed && measuring && scan_tick) begin
        tel_valid_out <= 1'b1;
        tel_type_out <= `STOC_TYPE_EVENT;
        tel_cmd_out <= `STOC_CMD_SCAN_READ;
        tel_result_out <= {7'h0, coarse};
        tel_scan_cnt_out <= scan_cnt;
        tel_iface_out <= req_iface;
      end
      if (!measuring && !cmd_wr)
        subscribed <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* tb/stoc_scan_model.sv */
// Purpose: Scan engine partner that marks the end of each scan.
// Assumes: One clock, async active-low reset.
// Notes: Runs free; a scan ends on each rising edge of scan_done_out.
`timescale 1ns/100ps
`default_nettype none
module stoc_scan_model #(
  parameter int PERIOD = 200
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  output logic scan_done_out
);
  int n;
  // The level is held 8 cycles so the input synchroniser cannot miss it.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      n <= 0;
      scan_done_out <= 1'b0;
    end else begin
      n <= (n == PERIOD - 1) ? 0 : n + 1;
      scan_done_out <= (n < 8);
    end
  end
endmodule
`default_nettype wire

/* tb/stoc_checker.sv */
// Purpose: Port assertions for the scan telegram controller.
// Assumes: One clock, async active-low reset.
// Notes: Attached by bind.
`timescale 1ns/100ps
`default_nettype none
`include "stoc_regs.vh"
module stoc_checker #(
  parameter FULL_VARIANT = 1,
  parameter OUTDOOR = 1
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [5:0] avs_address_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic avs_waitrequest_out,
  input wire logic contam_warn_in,
  input wire logic contam_err_in,
  input wire logic led_warn_out,
  input wire logic led_err_out,
  input wire logic dout_out,
  input wire logic fog_enable_out,
  input wire logic [7:0] open_angle_out,
  input wire logic tel_valid_out,
  input wire logic [2:0] tel_type_out,
  input wire logic [15:0] tel_scan_cnt_out,
  input wire logic tel_iface_out
);
  wire logic acc = avs_write_in && !avs_waitrequest_out && avs_address_in == `STOC_OFS_CMD;
  wire logic [2:0] c = avs_writedata_in[2:0];
  wire logic ev = tel_valid_out && tel_type_out == `STOC_TYPE_EVENT;
  logic sub_if;
  logic have;
  logic [15:0] last;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // ***************************************************
  // Helper state and assertions.
  // ***************************************************
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sub_if <= 1'b0;
      have <= 1'b0;
      last <= 16'h0000;
    end else begin
      if (acc && c == `STOC_CMD_SCAN_SUB && avs_writedata_in[8])
        sub_if <= avs_writedata_in[9];
      if (tel_valid_out && tel_type_out == `STOC_TYPE_EVENT_ACK)
        have <= 1'b0;
      if (ev) begin
        have <= 1'b1;
        last <= tel_scan_cnt_out;
      end
    end
  end
  a_warn_light: assert property ($stable(contam_warn_in)[*4] |-> led_warn_out == contam_warn_in)
    else $error("warning light does not follow input");
  a_err_light: assert property ($stable(contam_err_in)[*4] |-> led_err_out == contam_err_in)
    else $error("error light does not follow input");
  a_err_output: assert property (contam_err_in[*4] |-> dout_out)
    else $error("switching output misses contamination error");
  a_fog_forced: assert property (OUTDOOR == 1 && $past(rst_n_in, 2) |-> fog_enable_out)
    else $error("fog filter off on outdoor build");
  a_full_angle: assert property (FULL_VARIANT == 1 |-> open_angle_out == `STOC_OPEN_FULL)
    else $error("opening angle restricted on full build");
  a_ack_cause: assert property (tel_valid_out && tel_type_out == `STOC_TYPE_EVENT_ACK
    |-> $past(acc && c == `STOC_CMD_SCAN_SUB, 2))
    else $error("event ack without subscribe command");
  a_read_cause: assert property (tel_valid_out && tel_type_out == `STOC_TYPE_READ_ANS
    |-> $past(acc && (c == `STOC_CMD_SCAN_READ || c == `STOC_CMD_QUERY), 2))
    else $error("read answer without read request");
  a_event_iface: assert property (ev |-> tel_iface_out == sub_if)
    else $error("event on wrong interface");
  a_scan_count: assert property (ev && have |-> tel_scan_cnt_out == last + 16'h0001)
    else $error("scan counter skipped while subscribed");
  c_ack: cover property (tel_valid_out && tel_type_out == `STOC_TYPE_EVENT_ACK);
  c_event: cover property (ev && have);
  c_read: cover property (tel_valid_out && tel_type_out == `STOC_TYPE_READ_ANS);
endmodule
bind stoc_core stoc_checker #(.FULL_VARIANT(FULL_VARIANT), .OUTDOOR(OUTDOOR)) stoc_checker_i (
  .clk_in, .rst_n_in, .avs_address_in, .avs_write_in, .avs_writedata_in, .avs_waitrequest_out,
  .contam_warn_in, .contam_err_in, .led_warn_out, .led_err_out, .dout_out, .fog_enable_out,
  .open_angle_out, .tel_valid_out, .tel_type_out, .tel_scan_cnt_out, .tel_iface_out);
`default_nettype wire

/* tb/tb.sv */
// Purpose: Self-checking bench for the scan telegram controller.
// Assumes: Avalon-MM master tasks, 100 MHz clock.
// Notes: Scan ends come from the partner model every 200 cycles.
`timescale 1ns/100ps
`default_nettype none
`include "stoc_regs.vh"
module tb;
  logic clk_in = 0, rst_n_in = 0, avs_read_in = 0, avs_write_in = 0, scan_done_in;
  logic contam_warn_in = 0, contam_err_in = 0, field_hit_in = 0;
  logic [5:0] avs_address_in = 6'h00;
  logic [31:0] avs_writedata_in = 32'h0, d;
  logic [3:0] avs_byteenable_in = 4'hf;
  logic [1:0] r;
  wire [31:0] avs_readdata_out;
  wire [1:0] avs_response_out, echo_mode_out;
  wire avs_waitrequest_out, led_warn_out, led_err_out, dout_out, field_alarm_out;
  wire tel_valid_out, tel_iface_out, fog_enable_out;
  wire [2:0] tel_type_out, tel_cmd_out;
  wire [7:0] tel_result_out, open_angle_out;
  wire [15:0] tel_scan_cnt_out;
  int bad_count = 0, n_compared = 0, n_tel = 0, n_evt = 0, cyc = 0, i;
  logic [2:0] last_type;
  logic last_if;
  // ***************************************************
  // Clock, design, partner and telegram monitor.
  // ***************************************************
  always #5 clk_in = ~clk_in;
  stoc_core stoc_core_i (.clk_in, .rst_n_in, .avs_address_in, .avs_read_in, .avs_write_in,
    .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out, .avs_waitrequest_out,
    .avs_response_out, .scan_done_in, .contam_warn_in, .contam_err_in, .field_hit_in,
    .led_warn_out, .led_err_out, .dout_out, .field_alarm_out, .tel_valid_out, .tel_type_out,
    .tel_cmd_out, .tel_result_out, .tel_scan_cnt_out, .tel_iface_out, .fog_enable_out,
    .echo_mode_out, .open_angle_out);
  stoc_scan_model #(.PERIOD(200)) stoc_scan_model_i (.clk_in, .rst_n_in,
    .scan_done_out(scan_done_in));
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (tel_valid_out === 1'b1) begin
      n_tel <= n_tel + 1;
      last_type <= tel_type_out;
      last_if <= tel_iface_out;
      if (tel_type_out === `STOC_TYPE_EVENT) n_evt <= n_evt + 1;
    end
    if (cyc > 6000) begin
      bad_count = bad_count + 1;
      $display("BAD timeout expected end seen cycle %0d", cyc);
      results();
    end
  end
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task acc(input logic rd, input logic [5:0] a, input logic [31:0] w);
    @(posedge clk_in);
    avs_address_in <= a;
    avs_writedata_in <= w;
    avs_read_in <= rd;
    avs_write_in <= !rd;
    do begin
      @(posedge clk_in);
    end while (avs_waitrequest_out !== 1'b0);
    d = avs_readdata_out;
    r = avs_response_out;
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
  endtask
  task cmd(input logic [2:0] c, input logic a, input logic f);
    acc(0, `STOC_OFS_CMD, {22'h0, f, a, 5'h0, c});
  endtask
  task ans(input logic [2:0] c);
    cmd(c, 0, 0);
    acc(1, `STOC_OFS_ANSWER, 0);
    chk("result", 0, d[7:0]);
    chk("echo", c, d[10:8]);
    chk("type", `STOC_TYPE_METHOD_ANS, d[16:14]);
  endtask
  task results;
    $display("compared %0d bad %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk_in);
    rst_n_in <= 1'b1;
    acc(1, `STOC_OFS_STATUS, 0);
    chk("idle", `STOC_STATE_IDLE, d[3:0]);
    cmd(`STOC_CMD_SCAN_READ, 0, 0);
    repeat (4) @(posedge clk_in);
    chk("early read", 0, n_tel);
    $display("test reset done");
    ans(`STOC_CMD_LOGIN);
    ans(`STOC_CMD_START);
    ans(`STOC_CMD_RUN);
    acc(1, `STOC_OFS_STATUS, 0);
    chk("starting", `STOC_STATE_STARTING, d[3:0]);
    i = 0;
    do begin
      acc(1, `STOC_OFS_STATUS, 0);
      i++;
    end while (d[3:0] !== `STOC_STATE_MEASURE && i < 100);
    chk("measuring", `STOC_STATE_MEASURE, d[3:0]);
    $display("test start done");
    repeat (250) @(posedge clk_in);
    i = n_tel;
    cmd(`STOC_CMD_SCAN_READ, 0, 0);
    repeat (3) @(posedge clk_in);
    chk("one read", i + 1, n_tel);
    chk("read type", `STOC_TYPE_READ_ANS, last_type);
    chk("read iface", 0, last_if);
    cmd(`STOC_CMD_SCAN_SUB, 1, 1);
    repeat (3) @(posedge clk_in);
    chk("sub ack", `STOC_TYPE_EVENT_ACK, last_type);
    i = n_evt;
    repeat (700) @(posedge clk_in);
    chk("events", 1, n_evt - i >= 3);
    chk("event iface", 1, last_if);
    cmd(`STOC_CMD_SCAN_SUB, 0, 1);
    repeat (3) @(posedge clk_in);
    chk("unsub ack", `STOC_TYPE_EVENT_ACK, last_type);
    i = n_evt;
    repeat (500) @(posedge clk_in);
    chk("stopped", i, n_evt);
    $display("test output done");
    for (i = 0; i < 3; i++) begin
      acc(0, `STOC_OFS_CTRL, i << 3);
      repeat (2) @(posedge clk_in);
      chk("echo mode", i, echo_mode_out);
      chk("fog", 1, fog_enable_out);
    end
    acc(1, 6'h3c, 0);
    chk("unmapped", 0, d);
    chk("response", 2, r);
    $display("test control done");
    @(posedge clk_in) field_hit_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    chk("field direct", 1, field_alarm_out);
    @(posedge clk_in) field_hit_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    chk("field clear", 0, field_alarm_out);
    acc(0, `STOC_OFS_CTRL, 32'h20);
    @(posedge scan_done_in);
    repeat (5) @(posedge clk_in);
    field_hit_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    chk("field held", 0, field_alarm_out);
    @(posedge scan_done_in);
    repeat (5) @(posedge clk_in);
    chk("field late", 1, field_alarm_out);
    i = n_tel;
    cmd(`STOC_CMD_SCAN_READ, 0, 0);
    repeat (3) @(posedge clk_in);
    chk("filtered read", i + 1, n_tel);
    $display("test filter done");
    acc(0, `STOC_OFS_CONFIG, 32'h11);
    acc(1, `STOC_OFS_SCALE, 0);
    chk("fine range", {15'h0, 1'b1, 8'h0, `STOC_RANGE_FINE}, d);
    acc(0, `STOC_OFS_CONFIG, 32'h54);
    acc(1, `STOC_OFS_SCALE, 0);
    chk("coarse range", {15'h0, 1'b1, 8'h0, `STOC_RANGE_COARSE}, d);
    acc(0, `STOC_OFS_CONFIG, 32'h50);
    acc(1, `STOC_OFS_CTRL, 0);
    chk("pair refused", 1, d[2]);
    acc(1, `STOC_OFS_CONFIG, 0);
    chk("pair kept", 32'h54, d);
    $display("test config done");
    @(posedge clk_in) contam_warn_in <= 1'b1;
    repeat (8) @(posedge clk_in);
    chk("warn light", 1, led_warn_out);
    acc(1, `STOC_OFS_STATUS, 0);
    chk("warn bit", 1, d[8]);
    @(posedge clk_in) contam_err_in <= 1'b1;
    repeat (8) @(posedge clk_in);
    chk("err light", 1, led_err_out);
    chk("dout", 1, dout_out);
    acc(1, `STOC_OFS_STATUS, 0);
    chk("err bit", 1, d[9]);
    chk("stopped state", `STOC_STATE_IDLE, d[3:0]);
    i = n_tel;
    cmd(`STOC_CMD_SCAN_READ, 0, 0);
    repeat (4) @(posedge clk_in);
    chk("no data", i, n_tel);
    $display("test contamination done");
    results();
  end
endmodule
`default_nettype wire
